// >>> rtl/dcm_cp_cal.sv
`timescale 1ns/100ps
module dcm_cp_cal (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ref_i,
    input wire logic start_i,
    output logic run_o,
    output logic done_o
);
    import dcm_pkg::*;
    logic ref_q_r;
    logic [6:0] cnt_r;
    logic ref_rise;

    assign ref_rise = ref_i & ~ref_q_r;

    // count reference edges; done is kept until reset so later starts reuse it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_q_r <= 1'b0;
            cnt_r <= 7'h00;
            run_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            ref_q_r <= ref_i;
            if (start_i && !run_o) begin
                run_o <= 1'b1;
                cnt_r <= 7'h00;
            end else if (run_o && ref_rise) begin
                cnt_r <= cnt_r + 7'h01;
                if (cnt_r == CAL_CYCLES - 7'h01) begin
                    run_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    property p_cal_len;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(done_o) |-> $past(cnt_r) == CAL_CYCLES - 7'h01 && $past(ref_rise);
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("cal ended early");

    property p_cal_sticky;
        @(posedge clk_i) disable iff (!rst_n_i)
        done_o |=> done_o;
    endproperty
    a_cal_sticky: assert property (p_cal_sticky) else $error("cal lost");
endmodule : dcm_cp_cal

// >>> rtl/dcm_pkg.sv
package dcm_pkg;
    // serial port framing: one instruction word then one data byte
    localparam int unsigned SPI_INSTR_W = 16;
    localparam int unsigned SPI_FRAME_W = 24;
    localparam int unsigned SPI_RW_BIT = 15;
    localparam int unsigned ADDR_W = 15;
    localparam int unsigned DATA_W = 8;
    // register addresses
    localparam logic [14:0] ADDR_IRQ_EN = 15'h001F;
    localparam logic [14:0] ADDR_IRQ_STAT = 15'h0023;
    localparam logic [14:0] ADDR_CTRL = 15'h0083;
    localparam logic [14:0] ADDR_STAT = 15'h0084;
    // plain configuration storage, index order is the slot number
    localparam int unsigned NSLOT = 19;
    localparam logic [14:0] CFG_ADDR [NSLOT] = '{
        15'h0085, 15'h0087, 15'h0088, 15'h0089, 15'h008A, 15'h008B, 15'h008C,
        15'h008D, 15'h01B0, 15'h01B5, 15'h01B9, 15'h01BB, 15'h01BC, 15'h01BE,
        15'h01BF, 15'h01C0, 15'h01C1, 15'h01C4, 15'h01C5};
    localparam int unsigned SL_FEEDBACK_DIVIDER_COUNT = 0;
    localparam int unsigned SL_LF_A = 1;
    localparam int unsigned SL_LF_B = 2;
    localparam int unsigned SL_LF_C = 3;
    localparam int unsigned SL_CP = 4;
    localparam int unsigned SL_POST = 5;
    localparam int unsigned SL_REFDIV = 6;
    localparam logic [7:0] CFG_RST = 8'h00;
    // control and status bit positions
    localparam int unsigned CTRL_EN = 4;
    localparam int unsigned CTRL_CAL_EN = 6;
    localparam int unsigned CTRL_RECAL = 7;
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam int unsigned STAT_LOCK = 1;
    localparam int unsigned STAT_CAL = 5;
    localparam int unsigned STAT_LOW = 6;
    localparam int unsigned STAT_UP = 7;
    localparam int unsigned IRQ_LOCK = 4;
    localparam logic [7:0] IRQ_MASK = 8'h30;
    // field widths
    localparam int unsigned LF_W = 4;
    localparam int unsigned CP_W = 6;
    localparam int unsigned REF_F_W = 6;
    localparam int unsigned POST_F_W = 5;
    localparam int unsigned FB_W = 9;
    // calibration and band search
    localparam logic [6:0] CAL_CYCLES = 7'h40;
    localparam int unsigned BAND_W = 9;
    localparam logic [8:0] BAND_MID = 9'h100;
    localparam logic [8:0] BAND_MAX = 9'h1FF;
    localparam logic [8:0] BAND_MIN = 9'h000;
    localparam logic [8:0] BAND_STEP = 9'h001;
    typedef enum logic [1:0] {
        PLL_OFF = 2'b00,
        PLL_CAL = 2'b01,
        PLL_SEARCH = 2'b10,
        PLL_LOCKED = 2'b11
    } dcm_pll_e;
    typedef enum logic [1:0] {
        SP_INSTR = 2'b00,
        SP_DATA = 2'b01,
        SP_DONE = 2'b10
    } dcm_spi_e;
endpackage : dcm_pkg

// >>> rtl/dcm_pll_ctrl.sv
`timescale 1ns/100ps
module dcm_pll_ctrl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_csb_n_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    input wire logic reference_clock_input_i,
    input wire logic pll_lock_i,
    input wire logic band_upper_i,
    input wire logic band_lower_i,
    output logic irq_o,
    output logic irq_oe_o,
    output logic pll_enable_o,
    output logic cp_cal_run_o,
    output logic [dcm_pkg::REF_F_W-1:0] reference_divide_factor_o,
    output logic [dcm_pkg::POST_F_W-1:0] vco_post_divide_factor_o,
    output logic [dcm_pkg::FB_W-1:0] feedback_divide_ratio_o,
    output logic [dcm_pkg::CP_W-1:0] cp_current_o,
    output logic [5*dcm_pkg::LF_W-1:0] loop_filter_o,
    output logic [dcm_pkg::BAND_W-1:0] vco_band_o
);
    import dcm_pkg::*;

    // returns {hit, slot} for a plain configuration address
    function automatic logic [5:0] cfg_slot(input logic [14:0] a);
        cfg_slot = 6'h00;
        for (int i = 0; i < NSLOT; i++) begin
            if (a == CFG_ADDR[i]) begin
                cfg_slot = {1'b1, 5'(i)};
            end
        end
    endfunction : cfg_slot

    // code 5 gives 32, the one valid factor the code table leaves out
    function automatic logic [5:0] ref_factor(input logic [2:0] code);
        case (code)
            3'h0: ref_factor = 6'h01;
            3'h1: ref_factor = 6'h02;
            3'h2: ref_factor = 6'h04;
            3'h3: ref_factor = 6'h08;
            3'h4: ref_factor = 6'h10;
            3'h5: ref_factor = 6'h20;
            default: ref_factor = 6'h01;
        endcase
    endfunction : ref_factor

    // code 0 is not a valid post-divider; reported as 0
    function automatic logic [4:0] post_factor(input logic [1:0] code);
        case (code)
            2'h1: post_factor = 5'h04;
            2'h2: post_factor = 5'h08;
            2'h3: post_factor = 5'h10;
            default: post_factor = 5'h00;
        endcase
    endfunction : post_factor

    logic wr_stb;
    logic rd_stb;
    logic [14:0] bus_addr;
    logic [7:0] bus_wdata;
    logic [7:0] rdata;
    logic [7:0] cfg_mem_r [NSLOT];
    logic [7:0] ctrl_r;
    logic [7:0] irq_en_r;
    logic [5:0] wslot;
    logic [5:0] rslot;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic ref_s;
    logic lock_s;
    logic up_s;
    logic low_s;
    dcm_pll_e st_r;
    logic [8:0] band_r;
    logic recal_q_r;
    logic recal_go;
    logic cal_start;
    logic cal_done;
    logic lock_bit;
    logic lock_seen_r;
    logic [1:0] ev;
    logic [1:0] ev_q_r;
    logic [1:0] irq_src_r;
    logic [7:0] status_w;
    logic [7:0] irq_stat_w;

    dcm_spi_slave u_spi (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sclk_i(spi_sclk_i),
        .csb_n_i(spi_csb_n_i),
        .sdi_i(spi_sdi_i),
        .rdata_i(rdata),
        .wr_o(wr_stb),
        .rd_o(rd_stb),
        .addr_o(bus_addr),
        .wdata_o(bus_wdata),
        .sdo_o(spi_sdo_o),
        .sdo_oe_o(spi_sdo_oe_o)
    );

    dcm_cp_cal u_cal (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ref_i(ref_s),
        .start_i(cal_start),
        .run_o(cp_cal_run_o),
        .done_o(cal_done)
    );

    // analog flags and the reference arrive asynchronously
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
        end else begin
            s1_r <= {band_lower_i, band_upper_i, pll_lock_i, reference_clock_input_i};
            s2_r <= s1_r;
        end
    end
    assign ref_s = s2_r[0];
    assign lock_s = s2_r[1];
    assign up_s = s2_r[2];
    assign low_s = s2_r[3];

    assign wslot = cfg_slot(bus_addr);
    assign rslot = cfg_slot(bus_addr);

    // plain tuning storage; the host owns the recommended values
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NSLOT; i++) begin
                cfg_mem_r[i] <= CFG_RST;
            end
        end else if (wr_stb && wslot[5]) begin
            cfg_mem_r[wslot[4:0]] <= bus_wdata;
        end
    end

    // control: enable, calibration enable (on at reset), recalibrate
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CTRL_RST;
            recal_q_r <= 1'b0;
        end else begin
            recal_q_r <= ctrl_r[CTRL_RECAL];
            if (wr_stb && bus_addr == ADDR_CTRL) begin
                ctrl_r <= bus_wdata;
            end
        end
    end
    assign recal_go = ctrl_r[CTRL_RECAL] & ~recal_q_r;

    // interrupt enables; only the lock and lost bits exist
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_en_r <= 8'h00;
        end else if (wr_stb && bus_addr == ADDR_IRQ_EN) begin
            irq_en_r <= bus_wdata & IRQ_MASK;
        end
    end

    // decoded divider settings handed to the analog loop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reference_divide_factor_o <= 6'h01;
            vco_post_divide_factor_o <= 5'h00;
            feedback_divide_ratio_o <= 9'h000;
            pll_enable_o <= 1'b0;
        end else begin
            reference_divide_factor_o <= ref_factor(cfg_mem_r[SL_REFDIV][2:0]);
            vco_post_divide_factor_o <= post_factor(cfg_mem_r[SL_POST][1:0]);
            feedback_divide_ratio_o <= {cfg_mem_r[SL_FEEDBACK_DIVIDER_COUNT], 1'b0};
            pll_enable_o <= ctrl_r[CTRL_EN];
        end
    end
    assign cp_current_o = cfg_mem_r[SL_CP][CP_W-1:0];
    // five filter fields: a low, a high, b low, b high, c low
    assign loop_filter_o = {cfg_mem_r[SL_LF_C][3:0], cfg_mem_r[SL_LF_B],
        cfg_mem_r[SL_LF_A]};

    // calibration starts only once, on the first enable after reset with the calibration enable bit set
    assign cal_start = st_r == PLL_OFF && ctrl_r[CTRL_EN] && ctrl_r[CTRL_CAL_EN]
        && !cal_done && !cp_cal_run_o;

    // multiplier sequencing and automatic band search
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= PLL_OFF;
            band_r <= BAND_MID;
        end else if (!ctrl_r[CTRL_EN]) begin
            st_r <= PLL_OFF;
        end else if (recal_go) begin
            st_r <= PLL_SEARCH;
            band_r <= BAND_MID;
        end else begin
            case (st_r)
                PLL_OFF: begin
                    st_r <= cal_start ? PLL_CAL : PLL_SEARCH;
                    band_r <= BAND_MID;
                end
                PLL_CAL: begin
                    if (cal_done) begin
                        st_r <= PLL_SEARCH;
                    end
                end
                PLL_SEARCH: begin
                    if (lock_s) begin
                        st_r <= PLL_LOCKED;
                    end else if (up_s && band_r != BAND_MAX) begin
                        band_r <= band_r + BAND_STEP;
                    end else if (low_s && band_r != BAND_MIN) begin
                        band_r <= band_r - BAND_STEP;
                    end
                end
                default: begin
                    if (!lock_s) begin
                        st_r <= PLL_SEARCH;
                    end
                end
            endcase
        end
    end
    assign vco_band_o = band_r;

    assign lock_bit = st_r == PLL_LOCKED;

    // read-only live status; reading has no side effect
    always_comb begin
        status_w = 8'h00;
        status_w[STAT_LOCK] = lock_bit;
        status_w[STAT_CAL] = cal_done;
        status_w[STAT_LOW] = ctrl_r[CTRL_EN] & low_s;
        status_w[STAT_UP] = ctrl_r[CTRL_EN] & up_s;
    end

    // lost is a level that rises when a held lock drops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_seen_r <= 1'b0;
            ev_q_r <= 2'b00;
        end else begin
            ev_q_r <= ev;
            if (!ctrl_r[CTRL_EN]) begin
                lock_seen_r <= 1'b0;
            end else if (lock_bit) begin
                lock_seen_r <= 1'b1;
            end
        end
    end
    assign ev = {lock_seen_r & ~lock_bit, lock_bit};

    // source flags: enable low forces clear, a new edge beats a clear write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_src_r <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!irq_en_r[IRQ_LOCK + i]) begin
                    irq_src_r[i] <= 1'b0;
                end else if (ev[i] && !ev_q_r[i]) begin
                    irq_src_r[i] <= 1'b1;
                end else if (wr_stb && bus_addr == ADDR_IRQ_STAT
                    && bus_wdata[IRQ_LOCK + i]) begin
                    irq_src_r[i] <= 1'b0;
                end
            end
        end
    end

    // enabled bits read the latched flag, disabled bits the live event
    assign irq_stat_w = ((irq_en_r & {2'b00, irq_src_r, 4'h0})
        | (~irq_en_r & {2'b00, ev, 4'h0})) & IRQ_MASK;

    // open drain: the pin is only ever pulled low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
            irq_oe_o <= 1'b0;
        end else begin
            irq_o <= 1'b0;
            irq_oe_o <= |irq_src_r;
        end
    end

    // read data; unmapped addresses read zero
    always_comb begin
        if (bus_addr == ADDR_CTRL) begin
            rdata = ctrl_r;
        end else if (bus_addr == ADDR_STAT) begin
            rdata = status_w;
        end else if (bus_addr == ADDR_IRQ_EN) begin
            rdata = irq_en_r;
        end else if (bus_addr == ADDR_IRQ_STAT) begin
            rdata = irq_stat_w;
        end else if (rslot[5]) begin
            rdata = cfg_mem_r[rslot[4:0]];
        end else begin
            rdata = 8'h00;
        end
    end

    property p_ref_dec;
        @(posedge clk_i) disable iff (!rst_n_i)
        cfg_mem_r[SL_REFDIV][2:0] == 3'h3 |=> reference_divide_factor_o == 6'h08;
    endproperty
    a_ref_dec: assert property (p_ref_dec) else $error("ref divide wrong");

    property p_fb;
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 feedback_divide_ratio_o == 9'($past(cfg_mem_r[SL_FEEDBACK_DIVIDER_COUNT]) * 2);
    endproperty
    a_fb: assert property (p_fb) else $error("feedback ratio wrong");

    property p_post;
        @(posedge clk_i) disable iff (!rst_n_i)
        cfg_mem_r[SL_POST][1:0] == 2'h3 |=> vco_post_divide_factor_o == 5'h10;
    endproperty
    a_post: assert property (p_post) else $error("post divide wrong");

    property p_en;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_stb && bus_addr == ADDR_CTRL && bus_wdata[CTRL_EN] |-> ##2 pll_enable_o;
    endproperty
    a_en: assert property (p_en) else $error("enable not applied");

    property p_cal_once;
        @(posedge clk_i) disable iff (!rst_n_i)
        cal_done |-> !cp_cal_run_o;
    endproperty
    a_cal_once: assert property (p_cal_once) else $error("cal rerun");

    property p_lock_off;
        @(posedge clk_i) disable iff (!rst_n_i)
        !ctrl_r[CTRL_EN] |=> !status_w[STAT_LOCK];
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock while off");

    property p_recal;
        @(posedge clk_i) disable iff (!rst_n_i)
        recal_go && ctrl_r[CTRL_EN] |=> band_r == BAND_MID && st_r == PLL_SEARCH;
    endproperty
    a_recal: assert property (p_recal) else $error("recal ignored");

    property p_band_up;
        @(posedge clk_i) disable iff (!rst_n_i)
        ctrl_r[CTRL_EN] && !recal_go && st_r == PLL_SEARCH && !lock_s && up_s
        && band_r != BAND_MAX |=> band_r == $past(band_r) + BAND_STEP;
    endproperty
    a_band_up: assert property (p_band_up) else $error("band not stepped");

    property p_irq_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        irq_en_r[IRQ_LOCK] && ev[0] && !ev_q_r[0] |=> irq_src_r[0] ##1 irq_oe_o;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("event lost");

    property p_irq_dis;
        @(posedge clk_i) disable iff (!rst_n_i)
        !irq_en_r[IRQ_LOCK] |=> !irq_src_r[0];
    endproperty
    a_irq_dis: assert property (p_irq_dis) else $error("source set while off");
endmodule : dcm_pll_ctrl

// >>> rtl/dcm_spi_slave.sv
`timescale 1ns/100ps
module dcm_spi_slave (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic csb_n_i,
    input wire logic sdi_i,
    input wire logic [7:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [14:0] addr_o,
    output logic [7:0] wdata_o,
    output logic sdo_o,
    output logic sdo_oe_o
);
    import dcm_pkg::*;
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic sclk_q_r;
    logic [15:0] sh_r;
    logic [4:0] cnt_r;
    logic [7:0] tx_r;
    logic rw_r;
    dcm_spi_e st_r;
    logic rise;
    logic fall;

    // pins are asynchronous: two flops, edges taken from the second only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= 3'h1;
            s2_r <= 3'h1;
            sclk_q_r <= 1'b0;
        end else begin
            s1_r <= {sdi_i, sclk_i, csb_n_i};
            s2_r <= s1_r;
            sclk_q_r <= s2_r[1];
        end
    end
    assign rise = s2_r[1] & ~sclk_q_r;
    assign fall = ~s2_r[1] & sclk_q_r;

    // frame: r/w bit, 15 address bits, 8 data bits, msb first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= SP_INSTR;
            sh_r <= 16'h0000;
            cnt_r <= 5'h00;
            rw_r <= 1'b0;
            addr_o <= 15'h0000;
            wdata_o <= 8'h00;
            wr_o <= 1'b0;
            rd_o <= 1'b0;
            tx_r <= 8'h00;
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else begin
            wr_o <= 1'b0;
            rd_o <= 1'b0;
            if (s2_r[0]) begin
                st_r <= SP_INSTR;
                cnt_r <= 5'h00;
                sdo_oe_o <= 1'b0;
            end else begin
                if (rise && st_r != SP_DONE) begin
                    sh_r <= {sh_r[14:0], s2_r[2]};
                    cnt_r <= cnt_r + 5'h01;
                end
                if (rd_o) begin
                    tx_r <= rdata_i;
                end
                case (st_r)
                    SP_INSTR: begin
                        if (rise && cnt_r == 5'(SPI_INSTR_W - 1)) begin
                            rw_r <= sh_r[SPI_RW_BIT - 1];
                            addr_o <= {sh_r[13:0], s2_r[2]};
                            rd_o <= sh_r[SPI_RW_BIT - 1];
                            st_r <= SP_DATA;
                        end
                    end
                    SP_DATA: begin
                        if (rw_r && fall) begin
                            sdo_o <= tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                            sdo_oe_o <= 1'b1;
                        end
                        if (rise && cnt_r == 5'(SPI_FRAME_W - 1)) begin
                            wdata_o <= {sh_r[6:0], s2_r[2]};
                            wr_o <= ~rw_r;
                            st_r <= SP_DONE;
                        end
                    end
                    default: begin
                        if (fall) begin
                            sdo_oe_o <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end
endmodule : dcm_spi_slave

// >>> verification/dcm_host_model.sv
`timescale 1ns/100ps
module dcm_host_model (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic sclk_o,
    output logic csb_n_o,
    output logic sdi_o
);
    // idle: deselected, serial clock parked low
    initial begin
        sclk_o = 1'b0;
        csb_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // five system clocks per half keeps the pin synchroniser margin
    task automatic half();
        repeat (5) @(posedge clk_i);
        #1;
    endtask : half
    // one frame: read flag, address, data byte, msb first
    task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [23:0] fr;
        fr = {rw, a, wd};
        csb_n_o = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk_o = 1'b0;
            sdi_o = fr[i];
            half();
            if (i < 8) rd[i] = sdo_i;
            sclk_o = 1'b1;
            half();
        end
        sclk_o = 1'b0;
        half();
        csb_n_o = 1'b1;
        half();
    endtask : xfer
endmodule : dcm_host_model

// >>> verification/dcm_pll_ctrl_tb_top.sv
`timescale 1ns/100ps
module dcm_pll_ctrl_tb_top;
    import dcm_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ref_clk = 1'b0, lock = 1'b0, up = 1'b0, low = 1'b0;
    logic sclk, csb_n, sdi, sdo, sdo_oe, irq, irq_oe, en, cal_run, sdo_line;
    logic [5:0] rf, cp;
    logic [4:0] pf;
    logic [8:0] fb, band;
    logic [19:0] lf;
    logic [7:0] rd, prev;
    logic [7:0] mdl [NSLOT];
    logic [31:0] seed = 32'h2A29E302, v;
    int fail_count = 0, check_count = 0, cyc = 0, runc = 0;
    // a released data line reads inverted, so a sample taken outside the drive shows up
    assign sdo_line = sdo_oe ? sdo : ~sdo;
    dcm_host_model u_dcm_host_model (.clk_i(clk_i), .sdo_i(sdo_line), .sclk_o(sclk),
        .csb_n_o(csb_n), .sdi_o(sdi));
    dcm_pll_ctrl u_dcm_pll_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk),
        .spi_csb_n_i(csb_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
        .reference_clock_input_i(ref_clk), .pll_lock_i(lock), .band_upper_i(up),
        .band_lower_i(low), .irq_o(irq), .irq_oe_o(irq_oe), .pll_enable_o(en),
        .cp_cal_run_o(cal_run), .reference_divide_factor_o(rf), .vco_post_divide_factor_o(pf),
        .feedback_divide_ratio_o(fb), .cp_current_o(cp), .loop_filter_o(lf), .vco_band_o(band));
    // 20 MHz system clock; reference at a sixth of it, well under clk/4
    initial forever #25 clk_i = ~clk_i;
    initial forever begin
        repeat (3) @(posedge clk_i);
        #1 ref_clk = ~ref_clk;
    end
    // hang guard and calibration length counter
    always @(posedge clk_i) begin
        cyc++;
        if (cal_run === 1'b1) runc++;
        if (cyc == 60000) begin
            fail_count++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] junk;
        u_dcm_host_model.xfer(1'b0, a, d, junk);
    endtask : wr
    task automatic rdv(input logic [14:0] a);
        u_dcm_host_model.xfer(1'b1, a, 8'h00, rd);
    endtask : rdv
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // host sequence: tuning, post divider, count, reference, enable last
    initial begin
        tick(6);
        rst_n_i = 1'b1;
        tick(3);
        chk("band", band, 9'h100);
        rdv(ADDR_CTRL);
        chk("ctrl", rd, CTRL_RST);
        wr(15'h0080, 8'h00);
        for (int i = 0; i < NSLOT; i++) begin
            v = xs();
            mdl[i] = v[7:0];
            wr(CFG_ADDR[i], mdl[i]);
        end
        for (int i = 0; i < NSLOT; i++) begin
            rdv(CFG_ADDR[i]);
            chk("cfg", rd, mdl[i]);
        end
        chk("cp", cp, mdl[SL_CP][5:0]);
        chk("lf", lf, {mdl[SL_LF_C][3:0], mdl[SL_LF_B], mdl[SL_LF_A]});
        for (int c = 0; c < 4; c++) begin
            wr(CFG_ADDR[SL_POST], 8'(c));
            chk("post", pf, (c == 0) ? 0 : 4 << (c - 1));
        end
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 6 : (k == 1) ? 127 : 6 + xs() % 122;
            wr(CFG_ADDR[SL_FEEDBACK_DIVIDER_COUNT], v[7:0]);
            chk("fb", fb, 2 * v);
        end
        for (int c = 7; c >= 0; c--) begin
            wr(CFG_ADDR[SL_REFDIV], 8'(c));
            chk("ref", rf, (c < 6) ? 1 << c : 1);
        end
        wr(CFG_ADDR[SL_REFDIV], 8'h03);
        chk("ref", rf, 8);
        wr(CFG_ADDR[9], 8'h09);
        wr(CFG_ADDR[11], 8'h13);
        wr(CFG_ADDR[18], 8'h06);
        wr(ADDR_IRQ_EN, IRQ_MASK);
        wr(ADDR_CTRL, 8'h50);
        chk("en", en, 1);
        chk("cal_run", cal_run, 1);
        tick(500);
        chk("cal_len", runc >= 378 && runc <= 390, 1);
        rdv(ADDR_STAT);
        chk("cal_done", rd[STAT_CAL], 1);
        lock = 1'b1;
        tick(10);
        chk("irq_lock", irq_oe, 1);
        chk("irq_pin", irq, 0);
        rdv(ADDR_STAT);
        chk("lock", rd[STAT_LOCK], 1);
        rdv(ADDR_IRQ_STAT);
        chk("irq_stat", rd[IRQ_LOCK], 1);
        wr(ADDR_IRQ_STAT, IRQ_MASK);
        chk("irq_clr", irq_oe, 0);
        lock = 1'b0;
        tick(10);
        rdv(ADDR_IRQ_STAT);
        chk("irq_lost", rd[5:4], 2'b10);
        up = 1'b1;
        tick(10);
        rdv(ADDR_STAT);
        chk("band_up", rd[STAT_UP], 1);
        prev = rd;
        wr(ADDR_STAT, 8'h00);
        rdv(ADDR_STAT);
        chk("stat_ro", rd, prev);
        chk("band_max", band, 9'h1FF);
        up = 1'b0;
        low = 1'b1;
        tick(10);
        rdv(ADDR_STAT);
        chk("band_low", rd[STAT_LOW], 1);
        runc = 0;
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_CTRL, 8'h50);
        tick(300);
        chk("band_min", band, 9'h000);
        low = 1'b0;
        tick(5);
        wr(ADDR_CTRL, 8'hD0);
        chk("recal_band", band, 9'h100);
        chk("no_recal_cp", runc, 0);
        rdv(15'h0100);
        chk("unmapped", rd, 8'h00);
        report_and_stop();
    end
endmodule : dcm_pll_ctrl_tb_top
